/* inc/sbc_event_pkg.sv */
// Contract
// - Summary bit 3 reads 1 exactly while a wake pin flag at 64h is pending.
// - Summary bit 2 reads 1 while any transceiver flag at 63h is pending.
// - Summary bit 1 reads 1 while any supply flag at 62h is pending.
// - Summary bit 0 reads 1 while any system flag at 61h is pending.
// - Set battery start flag, system bit 4, on leaving Off after power-on.
// - Set overheat warning flag, system bit 2, above threshold; never in Sleep.
// - Set serial fault flag, system bit 1, on frames not 16, 24 or 32 bits.
// - Serial fault also on illegal mode codes or locked writes; not in Sleep.
// - Set watchdog fault, bit 0, on overflow or early trigger in Window mode.
// - A Window mode watchdog failure also issues a system reset at once.
// - Timeout overflow resets only when the watchdog fault flag was already set.
// - Set supply bit 2 when a second supply overvoltage event is captured.
// - Set supply bit 1 when a second supply undervoltage event is captured.
// - Set main undervoltage flag, supply bit 0, below 90 percent; never in Sleep.
// - Main undervoltage capture ignores the main reset threshold selection.
// - Set frame error flag, transceiver bit 5, on a selective frame error.
// - Set bus silence flag, bit 4, after silence timeout if enabled and was active.
// - Writing 1 clears a flag, 0 leaves it; host clears only seen bits.
// - Flags set only when capture enabled; power-on, watchdog, frame error always.
// - Capture while transceiver offline with main supply on forces receive pin low.
// - Capture in Sleep turns main supply on and goes Standby via Reset; the code only raises o_wake_request.
package sbc_event_pkg;
    // Register addresses on the serial port
    localparam logic [6:0] ADDR_GLOBAL  = 7'h60;
    localparam logic [6:0] ADDR_SYSTEM  = 7'h61;
    localparam logic [6:0] ADDR_SUPPLY  = 7'h62;
    localparam logic [6:0] ADDR_TRX     = 7'h63;
    // Field positions
    localparam int SUM_SYS        = 0;
    localparam int SUM_SUP        = 1;
    localparam int SUM_TRX        = 2;
    localparam int SUM_WAKE       = 3;
    localparam int SYS_WATCHDOG   = 0;
    localparam int SYS_SERIAL     = 1;
    localparam int SYS_OVERHEAT   = 2;
    localparam int SYS_BATTERY    = 4;
    localparam int SUP_MAIN_UNDER = 0;
    localparam int SUP_AUX_UNDER  = 1;
    localparam int SUP_AUX_OVER   = 2;
    localparam int TRX_SILENCE    = 4;
    localparam int TRX_FRAME_ERR  = 5;
    // Implemented bits and reset values
    localparam logic [7:0] SYS_MASK      = 8'h17;
    localparam logic [7:0] SUP_MASK      = 8'h07;
    localparam logic [7:0] TRX_MASK      = 8'h30;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Legal frame lengths in bits
    localparam logic [5:0] FRAME_LEN_A   = 6'h10;
    localparam logic [5:0] FRAME_LEN_B   = 6'h18;
    localparam logic [5:0] FRAME_LEN_C   = 6'h20;
    // Bus silence time and derived cycle count
    localparam int CLK_FREQ_KHZ     = 200000;
    localparam int SILENCE_TIME_MS  = 1;
    localparam int SILENCE_CYCLES   = SILENCE_TIME_MS * CLK_FREQ_KHZ;
    typedef enum logic [1:0] {
        WD_AUTONOMOUS = 2'b00,
        WD_TIMEOUT    = 2'b01,
        WD_WINDOW     = 2'b10,
        WD_OFF        = 2'b11
    } wd_mode_t;
endpackage

/* rtl/event_flag_reg.sv */
`timescale 1ns/1ps
module event_flag_reg (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_set,
    input  wire logic [7:0] i_clr,
    input  wire logic [7:0] i_impl_mask,
    output logic      [7:0] o_flags
);
    import sbc_event_pkg::*;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    // Set beats a clear in the same cycle; unimplemented bits stay 0
    assign nxt_flags = ((flags_ff & ~i_clr) | i_set) & i_impl_mask;
    assign o_flags   = flags_ff;

    // Flag storage
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule // event_flag_reg

/* rtl/serial_frame_shifter.sv */
`timescale 1ns/1ps
module serial_frame_shifter (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_sclk,
    input  wire logic       i_csn_b,
    input  wire logic       i_sdi,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_load,
    output logic      [7:0] o_rx_byte,
    output logic            o_byte_done,
    output logic      [5:0] o_bit_count,
    output logic            o_frame_start,
    output logic            o_frame_end,
    output logic            o_sdo,
    output logic            o_sdo_oe
);
    logic       sclk_q_ff;
    logic       csn_q_ff;
    logic [7:0] tx_sh_ff;
    wire        sel      = ~i_csn_b;
    wire        sclk_rise = ~sclk_q_ff & i_sclk;
    wire        sclk_fall = sclk_q_ff & ~i_sclk;

    // Sample on falling clock, shift out on rising clock, count saturates
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            sclk_q_ff     <= 1'b0;
            csn_q_ff      <= 1'b1;
            tx_sh_ff      <= 8'h00;
            o_rx_byte     <= 8'h00;
            o_byte_done   <= 1'b0;
            o_bit_count   <= 6'h00;
            o_frame_start <= 1'b0;
            o_frame_end   <= 1'b0;
            o_sdo         <= 1'b0;
            o_sdo_oe      <= 1'b0;
        end else begin
            sclk_q_ff     <= i_sclk;
            csn_q_ff      <= i_csn_b;
            o_frame_start <= csn_q_ff & ~i_csn_b;
            o_frame_end   <= ~csn_q_ff & i_csn_b;
            o_sdo_oe      <= sel;
            o_byte_done   <= sel & sclk_fall & (o_bit_count[2:0] == 3'h7);
            if (csn_q_ff & ~i_csn_b) begin
                o_bit_count <= 6'h00;
            end else if (sel & sclk_fall) begin
                o_rx_byte <= {o_rx_byte[6:0], i_sdi};
                if (o_bit_count != 6'h3F) begin
                    o_bit_count <= o_bit_count + 6'h01;
                end
            end
            if (i_tx_load) begin
                tx_sh_ff <= i_tx_byte;
            end else if (sel & sclk_rise) begin
                o_sdo    <= tx_sh_ff[7];
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
        end
    end
endmodule // serial_frame_shifter

/* rtl/sbc_event_status.sv */
`timescale 1ns/1ps
module sbc_event_status #(
    parameter int P_SILENCE_CYCLES = sbc_event_pkg::SILENCE_CYCLES
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst_b,
    input  wire logic                     i_sclk,
    input  wire logic                     i_csn_b,
    input  wire logic                     i_sdi,
    output logic                          o_sdo,
    output logic                          o_sdo_oe,
    input  wire logic                     i_off_exit,
    input  wire logic                     i_sleep_mode,
    input  wire logic                     i_overtemp_warn,
    input  wire sbc_event_pkg::wd_mode_t  i_wd_mode,
    input  wire logic                     i_wd_overflow,
    input  wire logic                     i_wd_early,
    input  wire logic                     i_bad_ctrl_code,
    input  wire logic                     i_locked_write,
    input  wire logic                     i_aux_over,
    input  wire logic                     i_aux_under,
    input  wire logic                     i_main_under,
    input  wire logic                     i_frame_error,
    input  wire logic                     i_bus_active,
    input  wire logic                     i_wake_pin_pending,
    input  wire logic                     i_trx_offline,
    input  wire logic                     i_main_supply_on,
    input  wire logic                     i_en_overheat,
    input  wire logic                     i_en_serial,
    input  wire logic                     i_en_aux_over,
    input  wire logic                     i_en_aux_under,
    input  wire logic                     i_en_main_under,
    input  wire logic                     i_en_bus_silence,
    output logic                          o_sys_reset,
    output logic                          o_rxd_force_low,
    output logic                          o_wake_request
);
    import sbc_event_pkg::*;

    // Register image readback
    function automatic logic [7:0] read_reg(input logic [6:0] addr, input logic [7:0] sum,
                                            input logic [7:0] sys, input logic [7:0] sup,
                                            input logic [7:0] trx);
        logic [7:0] r;
        r = READ_UNMAPPED;
        if (addr == ADDR_GLOBAL) r = sum;
        if (addr == ADDR_SYSTEM) r = sys;
        if (addr == ADDR_SUPPLY) r = sup;
        if (addr == ADDR_TRX)    r = trx;
        return r;
    endfunction

    // Write data aimed at one register by a multi-byte frame
    function automatic logic [7:0] wr_for(input logic [6:0] reg_a, input logic [6:0] base,
                                          input logic [2:0] ndata, input logic [23:0] data);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if ((3'(k) < ndata) && (7'(base + 7'(k)) == reg_a)) r = r | data[8*k +: 8];
        end
        return r;
    endfunction

    // Serial front end wires
    logic [7:0] rx_byte;
    logic       byte_done;
    logic [5:0] bit_count;
    logic       frame_start;
    logic       frame_end;

    // Frame capture registers
    logic [6:0]  addr_ff;
    logic        ro_ff;
    logic [23:0] data_ff;
    logic [7:0]  tx_byte_ff;
    logic        tx_load_ff;

    // Edge detection and misc state
    logic        overtemp_q_ff;
    logic        aux_over_q_ff;
    logic        aux_under_q_ff;
    logic        main_under_q_ff;
    logic        was_active_ff;
    logic [23:0] silence_cnt_ff;
    logic [23:0] nxt_silence_cnt;
    logic        nxt_rxd_low;

    // Flag registers
    logic [7:0] sys_flags;
    logic [7:0] sup_flags;
    logic [7:0] trx_flags;
    logic [7:0] sys_set;
    logic [7:0] sup_set;
    logic [7:0] trx_set;
    logic [7:0] sys_clr;
    logic [7:0] sup_clr;
    logic [7:0] trx_clr;
    logic [7:0] global_sum;

    serial_frame_shifter u_shifter (
        .i_clk_sys     (i_clk_sys),
        .i_rst_b       (i_rst_b),
        .i_sclk        (i_sclk),
        .i_csn_b       (i_csn_b),
        .i_sdi         (i_sdi),
        .i_tx_byte     (tx_byte_ff),
        .i_tx_load     (tx_load_ff),
        .o_rx_byte     (rx_byte),
        .o_byte_done   (byte_done),
        .o_bit_count   (bit_count),
        .o_frame_start (frame_start),
        .o_frame_end   (frame_end),
        .o_sdo         (o_sdo),
        .o_sdo_oe      (o_sdo_oe)
    );

    // Frame decode: byte index, read address, length check
    wire [2:0] byte_idx = bit_count[5:3];
    wire [2:0] ndata    = (bit_count[5:3] == 3'h0) ? 3'h0 : 3'(bit_count[5:3] - 3'h1);
    wire [6:0] rd_base  = (byte_idx == 3'h1) ? rx_byte[7:1] : addr_ff;
    wire [6:0] rd_addr  = 7'(rd_base + 7'(byte_idx) - 7'h01);
    wire       len_ok   = (bit_count == FRAME_LEN_A) | (bit_count == FRAME_LEN_B)
                        | (bit_count == FRAME_LEN_C);
    wire       wr_commit = frame_end & len_ok & ~ro_ff;
    wire       bad_len   = frame_end & ~len_ok;

    // Summary is a live OR of each flag register; wake pin summary is passed in
    assign global_sum = {4'h0, i_wake_pin_pending, |trx_flags, |sup_flags, |sys_flags};

    // Edge detected events
    wire overtemp_rise   = i_overtemp_warn & ~overtemp_q_ff;
    wire aux_over_rise   = i_aux_over & ~aux_over_q_ff;
    wire aux_under_rise  = i_aux_under & ~aux_under_q_ff;
    wire main_under_rise = i_main_under & ~main_under_q_ff;

    // Watchdog failures and serial fault
    wire wd_win_fail  = (i_wd_mode == WD_WINDOW) & (i_wd_overflow | i_wd_early);
    wire wd_tout_fail = (i_wd_mode == WD_TIMEOUT) & i_wd_overflow;
    wire serial_fault = ~i_sleep_mode & i_en_serial
                      & (bad_len | i_bad_ctrl_code | i_locked_write);

    // Bus silence timeout: counts idle cycles only after activity was seen
    wire silence_run  = i_en_bus_silence & was_active_ff & ~i_bus_active;
    wire silence_hit  = silence_run & (silence_cnt_ff == 24'(P_SILENCE_CYCLES - 1));
    assign nxt_silence_cnt = silence_run ? 24'(silence_cnt_ff + 24'h000001) : 24'h000000;

    // System event sets
    always_comb begin
        sys_set                = 8'h00;
        sys_set[SYS_BATTERY]   = i_off_exit;
        sys_set[SYS_OVERHEAT]  = overtemp_rise & ~i_sleep_mode & i_en_overheat;
        sys_set[SYS_SERIAL]    = serial_fault;
        sys_set[SYS_WATCHDOG]  = wd_win_fail | wd_tout_fail;
    end

    // Supply event sets; the reset threshold choice has no say here
    always_comb begin
        sup_set                 = 8'h00;
        sup_set[SUP_AUX_OVER]   = aux_over_rise & i_en_aux_over;
        sup_set[SUP_AUX_UNDER]  = aux_under_rise & i_en_aux_under;
        sup_set[SUP_MAIN_UNDER] = main_under_rise & i_main_supply_on & ~i_sleep_mode
                                & i_en_main_under;
    end

    // Transceiver event sets
    always_comb begin
        trx_set                = 8'h00;
        trx_set[TRX_FRAME_ERR] = i_frame_error;
        trx_set[TRX_SILENCE]   = silence_hit;
    end

    // Write-one-to-clear from a committed frame; summary address takes no write
    assign sys_clr = wr_commit ? wr_for(ADDR_SYSTEM, addr_ff, ndata, data_ff) : 8'h00;
    assign sup_clr = wr_commit ? wr_for(ADDR_SUPPLY, addr_ff, ndata, data_ff) : 8'h00;
    assign trx_clr = wr_commit ? wr_for(ADDR_TRX, addr_ff, ndata, data_ff) : 8'h00;

    // Receive pin stays low from a capture until nothing is pending, while offline with main supply on
    wire any_set     = |{sys_set, sup_set, trx_set};
    wire any_pending = |global_sum;
    assign nxt_rxd_low = i_trx_offline & i_main_supply_on
                       & ((any_set) | (o_rxd_force_low & any_pending));

    event_flag_reg u_sys_flags (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_set       (sys_set),
        .i_clr       (sys_clr),
        .i_impl_mask (SYS_MASK),
        .o_flags     (sys_flags)
    );

    event_flag_reg u_sup_flags (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_set       (sup_set),
        .i_clr       (sup_clr),
        .i_impl_mask (SUP_MASK),
        .o_flags     (sup_flags)
    );

    event_flag_reg u_trx_flags (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_set       (trx_set),
        .i_clr       (trx_clr),
        .i_impl_mask (TRX_MASK),
        .o_flags     (trx_flags)
    );

    // Frame bytes: address byte first, then up to three data bytes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            addr_ff <= 7'h00;
            ro_ff   <= 1'b1;
            data_ff <= 24'h000000;
        end else if (byte_done) begin
            case (byte_idx)
                3'h1: begin
                    addr_ff <= rx_byte[7:1];
                    ro_ff   <= rx_byte[0];
                end
                3'h2: data_ff[7:0]   <= rx_byte;
                3'h3: data_ff[15:8]  <= rx_byte;
                3'h4: data_ff[23:16] <= rx_byte;
                default: data_ff <= data_ff;
            endcase
        end
    end

    // Next byte to shift out: zero during the address byte, then register images
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tx_load_ff <= 1'b0;
            tx_byte_ff <= 8'h00;
        end else begin
            tx_load_ff <= frame_start | byte_done;
            tx_byte_ff <= frame_start ? 8'h00
                        : read_reg(rd_addr, global_sum, sys_flags, sup_flags, trx_flags);
        end
    end

    // Input edge history and bus silence tracking
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            overtemp_q_ff   <= 1'b0;
            aux_over_q_ff   <= 1'b0;
            aux_under_q_ff  <= 1'b0;
            main_under_q_ff <= 1'b0;
            was_active_ff   <= 1'b0;
            silence_cnt_ff  <= 24'h000000;
        end else begin
            overtemp_q_ff   <= i_overtemp_warn;
            aux_over_q_ff   <= i_aux_over;
            aux_under_q_ff  <= i_aux_under;
            main_under_q_ff <= i_main_under;
            was_active_ff   <= i_bus_active | (was_active_ff & ~silence_hit);
            silence_cnt_ff  <= nxt_silence_cnt;
        end
    end

    // Reset request, receive pin hold and wake request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_sys_reset     <= 1'b0;
            o_rxd_force_low <= 1'b0;
            o_wake_request  <= 1'b0;
        end else begin
            o_sys_reset     <= wd_win_fail | (wd_tout_fail & sys_flags[SYS_WATCHDOG]);
            o_rxd_force_low <= nxt_rxd_low;
            o_wake_request  <= any_set & i_sleep_mode;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    sequence s_win_fail;
        wd_win_fail;
    endsequence
    sequence s_reset_and_flag;
        o_sys_reset && sys_flags[SYS_WATCHDOG];
    endsequence
    sequence s_capture_offline;
        any_set && i_trx_offline && i_main_supply_on;
    endsequence

    a_wake_summary:
        assert property (global_sum[SUM_WAKE] == i_wake_pin_pending)
        else $error("wake pin summary wrong");
    a_trx_summary:
        assert property (trx_set != 8'h00 |=> global_sum[SUM_TRX])
        else $error("transceiver summary missed a capture");
    a_sup_summary:
        assert property (sup_set != 8'h00 |=> global_sum[SUM_SUP])
        else $error("supply summary missed a capture");
    a_sys_summary:
        assert property (sys_flags == 8'h00 |-> !global_sum[SUM_SYS])
        else $error("system summary set with no flag");
    a_battery_start:
        assert property (i_off_exit |=> sys_flags[SYS_BATTERY])
        else $error("battery start flag not set");
    a_overheat_sleep:
        assert property (i_sleep_mode && !sys_flags[SYS_OVERHEAT] |=> !sys_flags[SYS_OVERHEAT])
        else $error("overheat flag set in sleep");
    a_serial_len:
        assert property (bad_len && !i_sleep_mode && i_en_serial |=> sys_flags[SYS_SERIAL])
        else $error("bad frame length not flagged");
    a_wd_window_reset:
        assert property (s_win_fail |=> s_reset_and_flag)
        else $error("window failure without reset and flag");
    a_wd_timeout_first:
        assert property (wd_tout_fail && !sys_flags[SYS_WATCHDOG]
                         |=> !o_sys_reset && sys_flags[SYS_WATCHDOG])
        else $error("first timeout overflow handled wrongly");
    a_main_under_sleep:
        assert property (i_sleep_mode && !sup_flags[SUP_MAIN_UNDER] |=> !sup_flags[SUP_MAIN_UNDER])
        else $error("main undervoltage set in sleep");
    a_clear_write:
        assert property (wr_commit && sys_set == 8'h00 |=> (sys_flags & $past(sys_clr)) == 8'h00)
        else $error("write one did not clear");
    a_silence_gate:
        assert property (!i_en_bus_silence |-> ##1 !$rose(trx_flags[TRX_SILENCE]))
        else $error("silence flagged while disabled");
    a_rxd_force:
        assert property (s_capture_offline |=> o_rxd_force_low)
        else $error("receive pin not forced low");
    a_sleep_wake:
        assert property (any_set && i_sleep_mode |=> o_wake_request)
        else $error("sleep capture gave no wake request");
    a_reserved_zero:
        assert property ((sys_flags & ~SYS_MASK) == 8'h00 && (sup_flags & ~SUP_MASK) == 8'h00
                         && (trx_flags & ~TRX_MASK) == 8'h00)
        else $error("reserved bit set");
    a_main_under_off:
        assert property (!i_main_supply_on && !sup_flags[SUP_MAIN_UNDER]
                         |=> !sup_flags[SUP_MAIN_UNDER])
        else $error("main undervoltage set with supply off");
    a_frame_error:
        assert property (i_frame_error |=> trx_flags[TRX_FRAME_ERR])
        else $error("frame error not flagged");
    a_silence_flag:
        assert property (silence_hit |=> trx_flags[TRX_SILENCE])
        else $error("bus silence not flagged");
    a_wake_quiet:
        assert property (!(any_set && i_sleep_mode) |=> !o_wake_request)
        else $error("wake request without sleep capture");
    a_reset_cause:
        assert property (!wd_win_fail && !wd_tout_fail |=> !o_sys_reset)
        else $error("system reset without watchdog failure");
endmodule // sbc_event_status

/* verification/host_serial_model.sv */
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output logic      o_sclk,
    output logic      o_csn_b,
    output logic      o_sdi
);
    // Undriven output line shows the inverse of its last value
    wire sdo_line = i_sdo_oe ? i_sdo : ~i_sdo;
    // Idle: deselected, clock low
    initial begin
        o_sclk = 1'b0;
        o_csn_b = 1'b1;
        o_sdi = 1'b0;
    end
    // One frame of n bits, MSB first, data left aligned; read bits taken before each fall
    task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
        r = '0;
        o_csn_b = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        for (int k = 0; k < n; k++) begin
            #1 o_sdi = d[31-k];
            o_sclk = 1'b1;
            repeat (4) @(posedge i_clk_sys);
            #1 r = {r[30:0], sdo_line};
            o_sclk = 1'b0;
            repeat (4) @(posedge i_clk_sys);
        end
        #1 o_csn_b = 1'b1;
        o_sdi = ~o_sdi; // Released line keeps no stale value
        repeat (8) @(posedge i_clk_sys);
        #1;
    endtask
endmodule // host_serial_model

/* verification/tb_sbc_event_status.sv */
`timescale 1ns/1ps
module tb_sbc_event_status;
    import sbc_event_pkg::*;
    logic clk = '0, rst_b = '0, sclk, csn_b, sdi, sdo, sdo_oe, rst_o, rxd_low, wake_o;
    logic sleep = '0, wake_p = '0, bus = '0, offl = '0, sup_on = '0, ovf = '0, early = '0;
    logic [7:0] ev = '0, m;
    logic [5:0] en = '1;
    logic [31:0] r;
    wd_mode_t wdm = WD_WINDOW;
    int flg[3] = '{0, 0, 0};
    int errors = 0, n_checks = 0, n_rst = 0, n_wake = 0, x_rst = 0, x_wake = 0;
    // Event table: target register, bit, blocked in Sleep, enable index
    localparam int REG_OF[8] = '{0, 0, 0, 0, 1, 1, 1, 2};
    localparam int BIT_OF[8] = '{4, 2, 1, 1, 2, 1, 0, 5};
    localparam int BLK[8] = '{0, 1, 1, 1, 0, 0, 1, 0};
    localparam int EN_OF[8] = '{-1, 0, 1, 1, 2, 3, 4, -1};
    always #2.5 clk = ~clk;
    sbc_event_status #(.P_SILENCE_CYCLES(20)) uut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_csn_b(csn_b), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_off_exit(ev[0]), .i_sleep_mode(sleep),
        .i_overtemp_warn(ev[1]), .i_wd_mode(wdm), .i_wd_overflow(ovf), .i_wd_early(early),
        .i_bad_ctrl_code(ev[2]), .i_locked_write(ev[3]), .i_aux_over(ev[4]),
        .i_aux_under(ev[5]), .i_main_under(ev[6]), .i_frame_error(ev[7]),
        .i_bus_active(bus), .i_wake_pin_pending(wake_p), .i_trx_offline(offl),
        .i_main_supply_on(sup_on), .i_en_overheat(en[0]), .i_en_serial(en[1]),
        .i_en_aux_over(en[2]), .i_en_aux_under(en[3]), .i_en_main_under(en[4]),
        .i_en_bus_silence(en[5]), .o_sys_reset(rst_o), .o_rxd_force_low(rxd_low),
        .o_wake_request(wake_o));
    host_serial_model host (.i_clk_sys(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk),
        .o_csn_b(csn_b), .o_sdi(sdi));
    // Count one-cycle output pulses
    always @(posedge clk) begin
        n_rst += int'(rst_o === 1'b1);
        n_wake += int'(wake_o === 1'b1);
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] e);
        host.xfer(16, {a, 1'b1, 24'h0}, r);
        chk("read data", e, r[7:0]);
    endtask
    task automatic check_all();
        rd(ADDR_SYSTEM, 8'(flg[0]));
        rd(ADDR_SUPPLY, 8'(flg[1]));
        rd(ADDR_TRX, 8'(flg[2]));
        rd(ADDR_GLOBAL, {4'h0, wake_p, flg[2] != 0, flg[1] != 0, flg[0] != 0});
    endtask
    // Write 1 to every flag of all three registers in one frame
    task automatic clr_all();
        host.xfer(32, {ADDR_SYSTEM, 1'b0, 24'hFFFFFF}, r);
        flg = '{0, 0, 0};
    endtask
    task automatic fire(int i);
        bit cap;
        cap = !(sleep && BLK[i]) && (EN_OF[i] < 0 || en[EN_OF[i]]) && (i != 6 || sup_on);
        ev[i] = 1'b1;
        tick(1);
        ev[i] = 1'b0;
        tick(3);
        if (cap) flg[REG_OF[i]] |= 1 << BIT_OF[i];
        if (cap && sleep) x_wake++;
        if (cap && offl && sup_on) chk("rxd low", 8'h01, {7'h0, rxd_low});
    endtask
    task automatic wd(wd_mode_t md, logic e);
        wdm = md;
        tick(1);
        if (md == WD_WINDOW || (md == WD_TIMEOUT && !e && flg[0][0])) x_rst++;
        if (md == WD_WINDOW || (md == WD_TIMEOUT && !e)) flg[0] |= 1;
        if (e) early = 1'b1;
        else ovf = 1'b1;
        tick(1);
        {ovf, early} = 2'h0;
        tick(3);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h2666));
        tick(3);
        rst_b = 1'b1;
        tick(2);
        check_all();
        rd(7'h65, READ_UNMAPPED);
        for (int i = 0; i < 8; i++) fire(i);
        sup_on = 1'b1;
        fire(6);
        sup_on = 1'b0;
        host.xfer(8, 32'hC3000000, r);
        flg[0] |= 2;
        bus = 1'b1;
        tick(2);
        bus = 1'b0;
        tick(30);
        flg[2] |= 16;
        wd(WD_WINDOW, 1'b0);
        wd(WD_WINDOW, 1'b1);
        host.xfer(16, {ADDR_SYSTEM, 1'b1, 8'hFF, 16'h0}, r);
        chk("read data", 8'(flg[0]), r[7:0]);
        wake_p = 1'b1;
        check_all();
        m = 8'($urandom);
        host.xfer(16, {ADDR_SYSTEM, 1'b0, m, 16'h0}, r);
        flg[0] &= ~int'(m);
        host.xfer(24, {ADDR_SUPPLY, 1'b0, 16'h0201, 8'h0}, r);
        flg[1] &= ~2;
        wr_glob: host.xfer(16, {ADDR_GLOBAL, 1'b0, 8'hFF, 16'h0}, r);
        check_all();
        clr_all();
        wd(WD_OFF, 1'b0);
        wd(WD_AUTONOMOUS, 1'b0);
        wd(WD_TIMEOUT, 1'b1);
        wd(WD_TIMEOUT, 1'b0);
        wd(WD_TIMEOUT, 1'b0);
        en = '0;
        for (int i = 0; i < 8; i++) fire(i);
        check_all();
        en = '1;
        sleep = 1'b1;
        for (int i = 0; i < 8; i++) fire(i);
        check_all();
        sleep = 1'b0;
        wake_p = 1'b0;
        clr_all();
        {offl, sup_on} = 2'h3;
        fire(7);
        clr_all();
        chk("rxd low", 8'h00, {7'h0, rxd_low});
        check_all();
        chk("reset pulses", 8'(x_rst), 8'(n_rst));
        chk("wake pulses", 8'(x_wake), 8'(n_wake));
        close_out();
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule // tb_sbc_event_status
